// [common/csc_pkg.sv]
// shared constants for the core storage cycle control block
package csc_pkg;
  // ****************************************
  // clock and timing chain shape
  // ****************************************
  localparam int CLK_NS = 40;               // 25 MHz system clock
  localparam int STAGES = 6;                // flip-flop stages in the chain
  localparam int PASSES = 3;                // chain passes per storage cycle
  localparam int STEPS = STAGES * PASSES;   // chain steps per storage cycle
  localparam int STEP_W = 5;                // width of a step index
  localparam int PASS_W = 2;                // width of a pass index
  localparam int CHAIN_FIRST = 0;           // stage set by the start signal
  localparam int CHAIN_LAST = STAGES - 1;   // stage that ends a pass
  // ****************************************
  // grant times, counted from the first request seen while idle
  // ****************************************
  localparam int EXT_GRANT_NS = 50;
  localparam int PROC_GRANT_NS = 75;
  localparam int ARB_W = 2;
  localparam logic [ARB_W-1:0] EXT_GRANT_CYC = ARB_W'((EXT_GRANT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [ARB_W-1:0] PROC_GRANT_CYC = ARB_W'((PROC_GRANT_NS + CLK_NS - 1) / CLK_NS);
  // ****************************************
  // cycle timing points in ns, and as chain steps
  // ****************************************
  localparam int RESUME_NS = 425;
  localparam int Z2X_FLAG_NS = 450;
  localparam int Z2X_XFER_NS = 500;
  localparam int PROT_SAMPLE_NS = 525;
  localparam int DATA_LOAD_NS = 560;
  localparam int PROT_WB_NS = 600;
  localparam logic [STEP_W-1:0] RESUME_STEP = STEP_W'(RESUME_NS / CLK_NS);
  localparam logic [STEP_W-1:0] Z2X_FLAG_STEP = STEP_W'(Z2X_FLAG_NS / CLK_NS);
  localparam logic [STEP_W-1:0] Z2X_XFER_STEP = STEP_W'(Z2X_XFER_NS / CLK_NS);
  localparam logic [STEP_W-1:0] PROT_SAMPLE_STEP = STEP_W'(PROT_SAMPLE_NS / CLK_NS);
  localparam logic [STEP_W-1:0] DATA_LOAD_STEP = STEP_W'(DATA_LOAD_NS / CLK_NS);
  localparam logic [STEP_W-1:0] PROT_WB_STEP = STEP_W'(PROT_WB_NS / CLK_NS);
  // ****************************************
  // storage phase windows, in chain steps
  // ****************************************
  localparam logic [STEP_W-1:0] READ_FIRST = 5'h01;
  localparam logic [STEP_W-1:0] READ_LAST = 5'h05;
  localparam logic [STEP_W-1:0] WRITE_FIRST = 5'h0f;
  localparam logic [STEP_W-1:0] WRITE_LAST = STEP_W'(STEPS - 1);
  // ****************************************
  // storage word layout
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int PAR_BIT = 16;
  localparam int PROT_BIT = 17;
  localparam int WORD_W = 18;
endpackage : csc_pkg

// [core/csc_parity.sv]
// odd parity generator and half-word parity fault check
`timescale 1ns/1ps
module csc_parity
  import csc_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic [W-1:0] data_i,
  input wire logic par_i,
  output logic new_par_o,
  output logic fault_o
);
  localparam int HALF = W / 2;
  wire lo_odd = ^data_i[HALF-1:0];          // low half
  wire hi_odd = ^{par_i, data_i[W-1:HALF]}; // high half with parity bit

  // odd parity over data and parity bit
  assign new_par_o = ~^data_i;
  // halves must differ in parity under odd parity
  assign fault_o = (lo_odd == hi_odd);
endmodule : csc_parity

// [core/csc_storage_ctrl.sv]
// storage cycle control: arbitration, timing points, protect and phases
`timescale 1ns/1ps
//
// Contract
// - request held until resume at 425 ns
// - new cycle waits until busy drops
// - resume sets z-to-x flag, copy at 500
// - flag sets or clears stored protect bit
// - six stages, three passes per cycle
// - start signal sets first chain stage
// - external_grant_time first, processor_grant_time unless priority
// - grant starts chain, busy blocks further grants
// - gate channel address, data only on writes
// - sample protect bit at 525 when enabled
// - external protect fault condition at 525
// - processor protect fault condition at 525
// - fault blocks data load, reported out
// - read write inhibit flags from chain
// - odd parity, halves equal means fault
// - protect bit written back at 600
module csc_storage_ctrl
  import csc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // processor side, same clock
  input wire logic proc_req_i,
  input wire logic proc_write_i,
  input wire logic [AW-1:0] proc_addr_i,
  input wire logic [DW-1:0] proc_data_i,
  input wire logic instr_unprot_i,
  input wire logic prot_switch_i,
  input wire logic wr_prot_bit_i,
  input wire logic set_protect_bit_op_i,
  output logic proc_resume_o,
  output logic z_to_x_flag_o,
  output logic z_to_x_xfer_o,
  // external channel pins
  input wire logic ext_req_i,
  input wire logic ext_write_i,
  input wire logic ext_protect_i,
  input wire logic [AW-1:0] ext_addr_i,
  input wire logic [DW-1:0] ext_data_i,
  output logic ext_resume_o,
  // core stack
  input wire logic [WORD_W-1:0] sense_data_i,
  output logic [AW-1:0] addr_o,
  output logic [WORD_W-1:0] data_o,
  output logic read_phase_o,
  output logic write_phase_o,
  output logic inhibit_phase_o,
  // status
  output logic busy_o,
  output logic proc_active_o,
  output logic ext_active_o,
  output logic [STAGES-1:0] chain_stage_o,
  output logic protect_fault_o,
  output logic parity_fault_o
);
  // ****************************************
  // external pin synchronisers
  // ****************************************
  logic [AW+DW+2:0] ext_meta;   // first stage, read only by ext_sync
  logic [AW+DW+2:0] ext_sync;   // second stage
  wire ext_req = ext_sync[0];
  wire ext_wr = ext_sync[1];
  wire ext_prot = ext_sync[2];
  wire [AW-1:0] ext_addr = ext_sync[AW+2:3];       // same latency as the request,
  wire [DW-1:0] ext_data = ext_sync[AW+DW+2:AW+3]; // so bus and request line up

  // two flops per pin, bus lines too, so no external pin is ever read raw
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta <= '0;
      ext_sync <= '0;
    end else begin
      ext_meta <= {ext_data_i, ext_addr_i, ext_protect_i, ext_write_i, ext_req_i};
      ext_sync <= ext_meta;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic busy;             // storage reference in progress
  logic proc_active;      // processor channel granted
  logic ext_active;       // external channel granted
  logic priority_flag;    // external request seen, holds off processor
  logic [ARB_W-1:0] arb_cnt; // cycles since a request seen while idle
  logic z2x_flag;         // z-to-x armed by resume
  logic z2x_xfer;         // one-cycle z-to-x copy strobe
  logic proc_resume;
  logic ext_resume;
  logic prot_fault;
  logic par_fault;
  logic prot_prev;        // protect bit as read from the core
  logic [AW-1:0] s_reg;   // storage address
  logic [WORD_W-1:0] z_reg; // storage data, parity, protect

  // ****************************************
  // timing chain and step decode
  // ****************************************
  logic [STEP_W-1:0] step;
  logic chain_run;
  logic chain_done;
  logic chain_start;

  csc_timing_chain #(.N_STAGES(STAGES), .N_PASSES(PASSES)) u_chain (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(chain_start),
    .stage_o(chain_stage_o),
    .step_o(step),
    .run_o(chain_run),
    .done_o(chain_done)
  );

  // every timing point is a chain step, never a free counter
  wire at_resume = chain_run && (step == RESUME_STEP);
  wire at_z2x_flag = chain_run && (step == Z2X_FLAG_STEP);
  wire at_z2x_xfer = chain_run && (step == Z2X_XFER_STEP);
  wire at_sample = chain_run && (step == PROT_SAMPLE_STEP);
  wire at_load = chain_run && (step == DATA_LOAD_STEP);
  wire at_wb = chain_run && (step == PROT_WB_STEP);
  wire at_read_end = chain_run && (step == READ_LAST);

  // ****************************************
  // arbitration
  // ****************************************
  wire any_req = proc_req_i | ext_req;
  wire grant_ext = !busy && ext_req && (arb_cnt == EXT_GRANT_CYC);
  wire grant_proc = !busy && !priority_flag && !grant_ext && proc_req_i
                    && (arb_cnt == PROC_GRANT_CYC);
  assign chain_start = grant_ext | grant_proc;

  // active channel selection
  wire chan_write = (proc_active & proc_write_i) | (ext_active & ext_wr);
  wire [DW-1:0] chan_data = ext_active ? ext_data : proc_data_i;
  wire [AW-1:0] grant_addr = grant_ext ? ext_addr : proc_addr_i;
  wire ext_fault_cond = ext_active & ext_wr & ext_prot;
  wire proc_fault_cond = proc_active & proc_write_i & instr_unprot_i & prot_switch_i;
  wire wp_keep = ext_fault_cond | (proc_active & proc_write_i & ~instr_unprot_i);
  wire wp_bit = proc_active & wr_prot_bit_i;

  // parity of the word coming off the sense amplifiers, and of new data
  logic par_err;
  logic new_par;
  csc_parity #(.W(DW)) u_sense_par (
    .data_i(sense_data_i[DW-1:0]),
    .par_i(sense_data_i[PAR_BIT]),
    .new_par_o(),
    .fault_o(par_err)
  );
  csc_parity #(.W(DW)) u_write_par (
    .data_i(chan_data),
    .par_i(1'b0),
    .new_par_o(new_par),
    .fault_o()
  );

  // ****************************************
  // arbitration counter and priority
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arb_cnt <= '0;
      priority_flag <= 1'b0;
    end else if (busy || !any_req) begin
      arb_cnt <= '0;
      priority_flag <= 1'b0;
    end else begin
      // saturate so a late request still meets its grant time
      if (arb_cnt != PROC_GRANT_CYC) arb_cnt <= arb_cnt + 1'b1;
      priority_flag <= ext_req;
    end
  end

  // ****************************************
  // busy and channel active flags
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy <= 1'b0;
      proc_active <= 1'b0;
      ext_active <= 1'b0;
    end else if (chain_done) begin
      busy <= 1'b0;
      proc_active <= 1'b0;
      ext_active <= 1'b0;
    end else if (chain_start) begin
      busy <= 1'b1;
      proc_active <= grant_proc;
      ext_active <= grant_ext;
    end
  end

  // ****************************************
  // resume and z-to-x handshakes
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      proc_resume <= 1'b0;
      ext_resume <= 1'b0;
      z2x_flag <= 1'b0;
      z2x_xfer <= 1'b0;
    end else begin
      proc_resume <= at_resume & proc_active;
      ext_resume <= at_resume & ext_active;
      if (chain_done) z2x_flag <= 1'b0;
      else if (at_z2x_flag && proc_active) z2x_flag <= 1'b1;
      // the copy is held off on writes: z then holds outgoing data
      z2x_xfer <= at_z2x_xfer & z2x_flag & ~proc_write_i;
    end
  end

  // ****************************************
  // protect and parity faults
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prot_fault <= 1'b0;
      par_fault <= 1'b0;
    end else if (chain_done) begin
      prot_fault <= 1'b0;
      par_fault <= 1'b0;
    end else begin
      if (at_sample && z_reg[PROT_BIT] && (ext_fault_cond || proc_fault_cond))
        prot_fault <= 1'b1;
      if (at_read_end && par_err) par_fault <= 1'b1;
    end
  end

  // ****************************************
  // storage address and data registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      z_reg <= '0;
      prot_prev <= 1'b0;
    end else begin
      if (chain_start) s_reg <= grant_addr;
      if (at_read_end) begin
        z_reg <= sense_data_i;
        prot_prev <= sense_data_i[PROT_BIT];
      end else if (at_load && chan_write && !prot_fault) begin
        z_reg[DW-1:0] <= chan_data;
        z_reg[PAR_BIT] <= new_par;
      end else if (at_wb && wp_bit) begin
        z_reg[PROT_BIT] <= set_protect_bit_op_i;
      end else if (at_wb && wp_keep) begin
        z_reg[PROT_BIT] <= prot_prev;
      end
    end
  end

  // ****************************************
  // storage phase flags
  // ****************************************
  logic rd_ph;
  logic wr_ph;
  logic inh_ph;
  wire rd_win = chain_run && (step >= READ_FIRST) && (step <= READ_LAST);
  wire wr_win = chain_run && (step >= WRITE_FIRST) && (step <= WRITE_LAST);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
      inh_ph <= 1'b0;
    end else begin
      rd_ph <= rd_win;
      wr_ph <= wr_win;
      inh_ph <= wr_win;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign proc_resume_o = proc_resume;
  assign ext_resume_o = ext_resume;
  assign z_to_x_flag_o = z2x_flag;
  assign z_to_x_xfer_o = z2x_xfer;
  assign addr_o = s_reg;
  assign data_o = z_reg;
  assign read_phase_o = rd_ph;
  assign write_phase_o = wr_ph;
  assign inhibit_phase_o = inh_ph;
  assign busy_o = busy;
  assign proc_active_o = proc_active;
  assign ext_active_o = ext_active;
  assign protect_fault_o = prot_fault;
  assign parity_fault_o = par_fault;

  // ****************************************
  // assertions
  // ****************************************
  localparam int A_RES = RESUME_NS / CLK_NS + 1;
  localparam int A_LEN = STEPS;

  sequence s_grant;
    $rose(proc_active);
  endsequence
  sequence s_resume_pulse;
    proc_resume_o ##1 !proc_resume_o;
  endsequence

  property p_resume;
    @(posedge sys_clk_i) disable iff (!reset_n_i) s_grant |-> ##A_RES s_resume_pulse;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not at its step");

  property p_cycle_len;
    @(posedge sys_clk_i) disable iff (!reset_n_i) $rose(busy) |-> ##A_LEN !busy;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

  property p_busy_block;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      busy && !chain_done |=> !chain_start && (step == $past(step) + 5'h01);
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("start while busy");

  property p_z2x;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      z_to_x_xfer_o |-> $past(z2x_flag) && !$past(proc_write_i);
  endproperty
  a_z2x: assert property (p_z2x) else $error("z-to-x copy without flag or on write");

  property p_ext_fault;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (at_sample && z_reg[PROT_BIT] && ext_fault_cond) |=> protect_fault_o;
  endproperty
  a_ext_fault: assert property (p_ext_fault) else $error("external fault missed");

  property p_proc_fault;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (at_sample && z_reg[PROT_BIT] && proc_fault_cond) |=> protect_fault_o;
  endproperty
  a_proc_fault: assert property (p_proc_fault) else $error("processor fault missed");

  property p_fault_blocks;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (at_load && prot_fault) |=> $stable(data_o[DW-1:0]);
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("data loaded under fault");

  property p_wpb;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (at_wb && wp_bit) |=> data_o[PROT_BIT] == $past(set_protect_bit_op_i);
  endproperty
  a_wpb: assert property (p_wpb) else $error("protect bit not updated");

  property p_end_clear;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      chain_done |=> !busy && !proc_active && !ext_active && !prot_fault;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("state left at cycle end");
endmodule : csc_storage_ctrl

// [core/csc_timing_chain.sv]
// six-stage storage timing chain, three passes per storage cycle
`timescale 1ns/1ps
module csc_timing_chain
  import csc_pkg::*;
#(
  parameter int N_STAGES = STAGES,
  parameter int N_PASSES = PASSES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  output logic [N_STAGES-1:0] stage_o,
  output logic [STEP_W-1:0] step_o,
  output logic run_o,
  output logic done_o
);
  logic [N_STAGES-1:0] stage;      // one-hot chain stages
  logic [PASS_W-1:0] pass;         // current pass
  logic [N_STAGES-1:0] next_stage;
  logic last_pass;

  // index of the set stage in a one-hot word
  function automatic logic [STEP_W-1:0] stage_index(input logic [N_STAGES-1:0] s);
    logic [STEP_W-1:0] r;
    r = '0;
    for (int i = 0; i < N_STAGES; i++) begin
      if (s[i]) r = STEP_W'(i);
    end
    return r;
  endfunction : stage_index

  assign last_pass = (pass == PASS_W'(N_PASSES - 1));
  assign done_o = stage[N_STAGES-1] & last_pass;
  assign run_o = |stage;
  assign step_o = STEP_W'(pass * N_STAGES) + stage_index(stage);

  // ****************************************
  // stage shift: each stage sets the next and clears itself
  // ****************************************
  assign next_stage[CHAIN_FIRST] = start_i | (stage[N_STAGES-1] & ~last_pass);
  generate
    for (genvar g = 1; g < N_STAGES; g++) begin : g_shift
      assign next_stage[g] = stage[g-1];
    end
  endgenerate

  // stages and pass count
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage <= '0;
      pass <= '0;
    end else begin
      stage <= next_stage;
      if (start_i || done_o) pass <= '0;
      else if (stage[N_STAGES-1]) pass <= pass + 1'b1;
    end
  end

  assign stage_o = stage;

  property p_chain_onehot;
    @(posedge sys_clk_i) disable iff (!reset_n_i) $onehot0(stage);
  endproperty
  a_chain_onehot: assert property (p_chain_onehot) else $error("chain stages not one-hot");
endmodule : csc_timing_chain

// [tb/csc_far_model.sv]
// far-side model: request holders of both channels and a core stack word array
`timescale 1ns/1ps
module csc_far_model
  import csc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic proc_go_i,
  input wire logic ext_go_i,
  input wire logic proc_resume_i,
  input wire logic ext_resume_i,
  input wire logic read_phase_i,
  input wire logic write_phase_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [WORD_W-1:0] data_i,
  output logic proc_req_o,
  output logic ext_req_o,
  output logic [WORD_W-1:0] sense_data_o
);
  // ****************************************
  // core stack
  // ****************************************
  logic [WORD_W-1:0] mem [0:4095]; // stored words, start with good odd parity
  logic [WORD_W-1:0] idle_word; // flips every cycle so a late sample never matches
  initial begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 18'h10000;
  end
  // sense lines only carry the word during the read phase
  assign sense_data_o = read_phase_i ? mem[addr_i] : idle_word;
  // the write phase stores whatever the register holds, last edge wins
  always @(posedge sys_clk_i) begin
    if (reset_n_i && write_phase_i) begin
      mem[addr_i] <= data_i;
    end
  end
  // ****************************************
  // request holders
  // ****************************************
  // a request is posted on go and held until its resume is sampled
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      proc_req_o <= 1'b0;
      ext_req_o <= 1'b0;
      idle_word <= 18'h2aaaa;
    end else begin
      idle_word <= #1 ~idle_word;
      if (proc_go_i) begin
        proc_req_o <= #1 1'b1;
      end else if (proc_resume_i) begin
        proc_req_o <= #1 1'b0;
      end
      if (ext_go_i) begin
        ext_req_o <= #1 1'b1;
      end else if (ext_resume_i) begin
        ext_req_o <= #1 1'b0;
      end
    end
  end
endmodule : csc_far_model

// [tb/tb_csc_storage_ctrl.sv]
// self-checking bench for the storage cycle control block
`timescale 1ns/1ps
module tb_csc_storage_ctrl;
  import csc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, go_p = 1'b0, go_e = 1'b0;
  logic proc_req_i, proc_write_i = 1'b0, instr_unprot_i = 1'b0, prot_switch_i = 1'b0;
  logic wr_prot_bit_i = 1'b0, set_protect_bit_op_i = 1'b0, ext_req_i;
  logic ext_write_i = 1'b0, ext_protect_i = 1'b0;
  logic [11:0] proc_addr_i = 12'h000, ext_addr_i = 12'h000, adr;
  logic [15:0] proc_data_i = 16'h0000, ext_data_i = 16'h0000;
  logic [17:0] sense_data_i, data_o, word;
  logic [11:0] addr_o;
  logic [5:0] chain_stage_o;
  logic proc_resume_o, z_to_x_flag_o, z_to_x_xfer_o, ext_resume_o, read_phase_o, write_phase_o;
  logic inhibit_phase_o, busy_o, proc_active_o, ext_active_o, protect_fault_o, parity_fault_o;
  int failures = 0, n_compared = 0, cyc = 0;
  int res_at, flag_at, xfer_at, flt_at, par_n, busy_n, k0_n, rph, wph, ihp, act_n, oth_n;
  // ****************************************
  // design and far side
  // ****************************************
  csc_storage_ctrl dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .proc_req_i(proc_req_i),
    .proc_write_i(proc_write_i), .proc_addr_i(proc_addr_i), .proc_data_i(proc_data_i),
    .instr_unprot_i(instr_unprot_i), .prot_switch_i(prot_switch_i), .wr_prot_bit_i(wr_prot_bit_i),
    .set_protect_bit_op_i(set_protect_bit_op_i), .proc_resume_o(proc_resume_o),
    .z_to_x_flag_o(z_to_x_flag_o), .z_to_x_xfer_o(z_to_x_xfer_o), .ext_req_i(ext_req_i),
    .ext_write_i(ext_write_i), .ext_protect_i(ext_protect_i), .ext_addr_i(ext_addr_i),
    .ext_data_i(ext_data_i), .ext_resume_o(ext_resume_o), .sense_data_i(sense_data_i),
    .addr_o(addr_o), .data_o(data_o), .read_phase_o(read_phase_o), .write_phase_o(write_phase_o),
    .inhibit_phase_o(inhibit_phase_o), .busy_o(busy_o), .proc_active_o(proc_active_o),
    .ext_active_o(ext_active_o), .chain_stage_o(chain_stage_o), .protect_fault_o(protect_fault_o),
    .parity_fault_o(parity_fault_o));
  csc_far_model far_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .proc_go_i(go_p), .ext_go_i(go_e),
    .proc_resume_i(proc_resume_o), .ext_resume_i(ext_resume_o), .read_phase_i(read_phase_o),
    .write_phase_i(write_phase_o), .addr_i(addr_o), .data_i(data_o), .proc_req_o(proc_req_i),
    .ext_req_o(ext_req_i), .sense_data_o(sense_data_i));
  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // about a dozen references of some 25 cycles each, with wide margin
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test;
    end
  end
  task tick;
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // follow one reference from the first busy cycle, noting when each output shows
  task observe(input logic ext);
    res_at = -1;
    flag_at = -1;
    xfer_at = -1;
    flt_at = -1;
    par_n = 0;
    busy_n = 0;
    k0_n = 0;
    rph = 0;
    wph = 0;
    ihp = 0;
    act_n = 0;
    oth_n = 0;
    for (int i = 0; i < 10 && busy_o !== 1'b1; i++)
      tick;
    for (int i = 0; i < 19; i++) begin
      if (busy_o === 1'b1) busy_n++;
      if ((ext ? ext_resume_o : proc_resume_o) === 1'b1) res_at = i;
      if ((ext ? proc_resume_o | proc_active_o : ext_resume_o | ext_active_o) === 1'b1) oth_n++;
      if (z_to_x_flag_o === 1'b1 && flag_at < 0) flag_at = i;
      if (z_to_x_xfer_o === 1'b1) xfer_at = i;
      if (protect_fault_o === 1'b1 && flt_at < 0) flt_at = i;
      if (parity_fault_o === 1'b1) par_n++;
      if (chain_stage_o[0] === 1'b1) k0_n++;
      if (read_phase_o === 1'b1) rph++;
      if (write_phase_o === 1'b1) wph++;
      if (inhibit_phase_o === 1'b1) ihp++;
      if ((ext ? ext_active_o : proc_active_o) === 1'b1) act_n++;
      if (i == 0) adr = addr_o;
      if (i == 17) word = data_o;
      tick;
    end
  endtask : observe
  // post one request through the far side, then check the common cycle shape
  task run_ref(input logic ext, input logic wr, input logic prot, input logic [11:0] a, input logic [15:0] d);
    proc_write_i = wr & ~ext;
    ext_write_i = wr & ext;
    ext_protect_i = prot;
    proc_addr_i = a;
    ext_addr_i = a;
    proc_data_i = d;
    ext_data_i = d;
    go_p = ~ext;
    go_e = ext;
    tick;
    go_p = 1'b0;
    go_e = 1'b0;
    observe(ext);
    shape(ext, wr);
  endtask : run_ref
  task shape(input logic ext, input logic wr);
    check("resume step", 18'(res_at), 18'd11);
    check("other channel", 18'(oth_n), 18'd0);
    check("z flag step", 18'(flag_at), ext ? 18'h3ffff : 18'd12);
    check("z copy step", 18'(xfer_at), (wr | ext) ? 18'h3ffff : 18'd13);
    check("busy cycles", 18'(busy_n), 18'd18);
    check("active cycles", 18'(act_n), 18'd18);
    check("first stage", 18'(k0_n), 18'd3);
    check("phases", {6'(rph), 6'(wph), 6'(ihp)}, {6'd5, 6'd3, 6'd3});
  endtask : shape
  task end_of_test;
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    check("reset outputs", {busy_o, proc_resume_o, protect_fault_o}, 18'h0);
    reset_n_i = 1'b1;
    tick;
    // processor write, then read back with copy to x
    run_ref(1'b0, 1'b1, 1'b0, 12'h012, 16'h1234);
    check("address", {6'h0, adr}, 18'h00012);
    check("written word", word, {1'b0, ~^16'h1234, 16'h1234});
    check("no fault", 18'(flt_at), 18'h3ffff);
    run_ref(1'b0, 1'b0, 1'b0, 12'h012, 16'h0000);
    check("read word", word, {1'b0, ~^16'h1234, 16'h1234});
    check("no parity fault", 18'(par_n), 18'd0);
    // external protected write to a protected word is refused
    far_u.mem[12'h345] = {1'b1, ~^16'h00ff, 16'h00ff};
    run_ref(1'b1, 1'b1, 1'b1, 12'h345, 16'habcd);
    check("ext fault step", 18'(flt_at), 18'd14);
    check("blocked data", {2'b00, word[15:0]}, 18'h000ff);
    check("protect kept", {17'h0, word[17]}, 18'h1);
    check("fault cleared", {17'h0, protect_fault_o}, 18'h0);
    // processor write, unprotected instruction under the switch, then protected instruction
    instr_unprot_i = 1'b1;
    prot_switch_i = 1'b1;
    run_ref(1'b0, 1'b1, 1'b0, 12'h345, 16'h5555);
    check("proc fault step", 18'(flt_at), 18'd14);
    check("blocked data", {2'b00, word[15:0]}, 18'h000ff);
    instr_unprot_i = 1'b0;
    run_ref(1'b0, 1'b1, 1'b0, 12'h345, 16'h5555);
    check("proc no fault", 18'(flt_at), 18'h3ffff);
    prot_switch_i = 1'b0;
    // external write without its protect input ignores the stored bit
    far_u.mem[12'h346] = {1'b1, ~^16'h00ff, 16'h00ff};
    run_ref(1'b1, 1'b1, 1'b0, 12'h346, 16'h1111);
    check("ext no fault", 18'(flt_at), 18'h3ffff);
    check("ext data", {2'b00, word[15:0]}, 18'h01111);
    // stored word with both halves of even parity
    far_u.mem[12'h0a0] = {1'b0, ^16'h0f0f, 16'h0f0f};
    run_ref(1'b0, 1'b0, 1'b0, 12'h0a0, 16'h0000);
    check("parity fault", {17'h0, par_n != 0}, 18'h1);
    // set and then clear the stored protect bit
    wr_prot_bit_i = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      set_protect_bit_op_i = k[0];
      run_ref(1'b0, 1'b0, 1'b0, 12'h0b0, 16'h0000);
      check("protect bit op", {17'h0, word[17]}, 18'(k));
    end
    wr_prot_bit_i = 1'b0;
    // both channels at once: external first, processor waits for busy to drop
    go_p = 1'b1;
    go_e = 1'b1;
    tick;
    go_p = 1'b0;
    go_e = 1'b0;
    observe(1'b1);
    shape(1'b1, 1'b0);
    observe(1'b0);
    shape(1'b0, 1'b0);
    end_of_test;
  end
endmodule : tb_csc_storage_ctrl
